// ==== hdl/emmc_signalling.sv ====
// Top of the card-bus signalling layer: APB registers on the core clock,
// link end on the host card clock. Assumes an APB master on i_core_clk.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module emmc_signalling
   import emmc_sig_pkg::*;
#(
   parameter logic [31:0] CAPACITY_SECTORS = 32'h0100_0000
)
(
   // Core clock and reset.
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Card clock and pins.
   input  wire logic        i_card_clk,
   input  wire logic        i_hw_rst_n,
   input  wire logic        i_cmd_in,
   output logic             o_cmd_out,
   output logic             o_cmd_oe_n,
   output logic [7:0]       o_dat_out,
   output logic [7:0]       o_dat_oe_n,
   output logic [7:0]       o_dat_pullup,
   output logic             o_strobe,
   output logic             o_byte_mode,
   output logic [31:0]      o_mem_addr
);
   // ****************************************************************
   // Register decode.
   // ****************************************************************
   logic [31:0] ctrl;
   logic [7:0]  tx_byte;
   logic [31:0] next_ctrl;
   logic [31:0] rd_mux;
   logic [1:0]  rst_pin_sync;
   logic        hw_rst_hit;
   logic        dev_rst;
   logic        wr_en;
   logic        hit;
   logic        strobe_ok;
   logic [7:0]  cmd_shift_link;
   logic [7:0]  cmd_meta;
   logic [7:0]  cmd_core;
   logic [31:0] sector_addr;
   logic        byte_mode;

   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign hit     = (paddr == OFS_CTRL) | (paddr == OFS_STATUS) |
                    (paddr == OFS_TXDATA) | (paddr == OFS_CAP) |
                    (paddr == OFS_OCR);
   assign pslverr = psel & penable & ~hit;

   // Reset pin passes two flops and only counts when enabled.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rst_pin_sync <= 2'h3;
      end else begin
         rst_pin_sync <= {rst_pin_sync[0], i_hw_rst_n};
      end
   end
   assign hw_rst_hit = ctrl[CTRL_RST_EN] & ~rst_pin_sync[1];
   // Power-on, pin and soft command all give the reset state.
   assign dev_rst = i_rst | hw_rst_hit | ctrl[CTRL_SOFT_RST];

   // Strobe mode is only honoured with an 8-bit bus at 1.8 V.
   assign strobe_ok = pwdata[CTRL_STROBE] & pwdata[CTRL_DDR] &
                      pwdata[CTRL_LV18] &
                      (pwdata[CTRL_WIDTH_LSB +: 2] == WIDTH_8);

   always_comb begin
      next_ctrl = pwdata;
      next_ctrl[CTRL_STROBE] = strobe_ok;
   end

   always_ff @(posedge i_core_clk) begin
      if (dev_rst) begin
         ctrl    <= CTRL_RESET;
         tx_byte <= 8'h00;
      end else if (wr_en && paddr == OFS_CTRL) begin
         ctrl <= next_ctrl;
      end else if (wr_en && paddr == OFS_TXDATA) begin
         tx_byte <= pwdata[7:0];
      end
   end

   // ****************************************************************
   // Addressing mode.
   // ****************************************************************
   assign byte_mode   = (CAPACITY_SECTORS <= BYTE_ADDR_LIMIT);
   assign sector_addr = {24'h000000, cmd_core};
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_addr <= 32'h0000_0000;
      end else begin
         // Byte address or sector number times 512.
         o_mem_addr <= byte_mode ? sector_addr :
                       (sector_addr << SECTOR_SHIFT);
      end
   end
   assign o_byte_mode = byte_mode;

   // Read mux; OCR carries the addressing mode in 30:29.
   assign rd_mux =
      (paddr == OFS_CTRL)   ? ctrl :
      (paddr == OFS_STATUS) ? {24'h000000, cmd_core} :
      (paddr == OFS_TXDATA) ? {24'h000000, tx_byte} :
      (paddr == OFS_CAP)    ? CAPACITY_SECTORS :
      (paddr == OFS_OCR)    ? {1'b0, (byte_mode ? OCR_MODE_BYTE :
                               OCR_MODE_SECTOR), 29'h00000000} :
                              32'h0000_0000;
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Pull-ups off on lane 0, lanes 0-3 or lanes 0-7 per width.
   assign o_dat_pullup =
      (ctrl[CTRL_WIDTH_LSB +: 2] == WIDTH_8) ? 8'h00 :
      (ctrl[CTRL_WIDTH_LSB +: 2] == WIDTH_4) ? 8'hF0 : 8'hFE;

   // ****************************************************************
   // Crossings.
   // ****************************************************************
   // Control levels are quasi-static; each bit is synchronised twice.
   // Link logic keeps state through a stopped clock: no timeouts.
   logic [15:0] ctl_core;
   logic [15:0] ctl_m;
   logic [15:0] ctl_s;
   logic [1:0]  lrst_m;
   logic        rst_req;
   logic [1:0]  rst_ack;
   // Reset request stands until the link side echoes it back, so a short
   // reset is not lost on a slow or stopped card clock.
   always_ff @(posedge i_core_clk) begin
      if (dev_rst) begin
         rst_req <= 1'b1;
      end else if (rst_ack[1]) begin
         rst_req <= 1'b0;
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rst_ack <= 2'h0;
      end else begin
         rst_ack <= {rst_ack[0], lrst_m[1]};
      end
   end
   assign ctl_core = {tx_byte, ctrl[CTRL_CRC_STAT], ctrl[CTRL_RESP_EN],
                      ctrl[CTRL_DRIVE], ctrl[CTRL_STROBE], ctrl[CTRL_DDR],
                      ctrl[CTRL_CMD_PP], ctrl[CTRL_WIDTH_LSB +: 2]};
   always_ff @(posedge i_card_clk) begin
      ctl_m  <= ctl_core;
      ctl_s  <= ctl_m;
      lrst_m <= {lrst_m[0], rst_req};
   end
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cmd_meta <= 8'h00;
         cmd_core <= 8'h00;
      end else begin
         cmd_meta <= cmd_shift_link;
         cmd_core <= cmd_meta;
      end
   end

   emmc_link_end u_link (
      .i_card_clk    (i_card_clk),
      .i_link_rst    (lrst_m[1]),
      .i_width       (ctl_s[1:0]),
      .i_cmd_pp      (ctl_s[2]),
      .i_ddr         (ctl_s[3]),
      .i_strobe_mode (ctl_s[4]),
      .i_drive       (ctl_s[5]),
      .i_resp_en     (ctl_s[6]),
      .i_crc_stat    (ctl_s[7]),
      .i_tx_byte     (ctl_s[15:8]),
      .i_cmd_in      (i_cmd_in),
      .o_cmd_out     (o_cmd_out),
      .o_cmd_oe_n    (o_cmd_oe_n),
      .o_dat_out     (o_dat_out),
      .o_dat_oe_n    (o_dat_oe_n),
      .o_strobe      (o_strobe),
      .o_cmd_shift   (cmd_shift_link)
   );

   // ****************************************************************
   // Checks.
   // ****************************************************************
   chk_reset_ctrl: assert property (@(posedge i_core_clk)
      $past(dev_rst) |-> ctrl == CTRL_RESET)
      else $error("ctrl not cleared by reset");
   chk_pin_ignored: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      (!ctrl[CTRL_RST_EN] && !ctrl[CTRL_SOFT_RST] && !wr_en) |=>
      $stable(ctrl))
      else $error("reset pin acted while disabled");
   chk_pullup_width: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      (ctrl[1:0] == WIDTH_8) |-> o_dat_pullup == 8'h00)
      else $error("pull-ups held in 8-bit mode");
   chk_strobe_legal: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      ctrl[CTRL_STROBE] |-> (ctrl[1:0] == WIDTH_8 && ctrl[CTRL_LV18]))
      else $error("strobe mode without 8-bit 1.8 V");
   chk_ocr_mode: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      (psel && !penable && !pwrite && paddr == OFS_OCR) |=>
      prdata[30:29] == (byte_mode ? OCR_MODE_BYTE : OCR_MODE_SECTOR))
      else $error("ocr mode bits wrong");
   chk_strobe_idle: assert property (@(negedge i_card_clk)
      disable iff (lrst_m[1])
      !ctl_s[4] |-> !o_strobe)
      else $error("strobe toggled outside strobe mode");
   chk_lane_one: assert property (@(posedge i_card_clk)
      disable iff (lrst_m[1])
      (ctl_s[1:0] == WIDTH_1) |-> o_dat_oe_n[7:1] == 7'h7F)
      else $error("upper lanes driven in 1-bit mode");
   chk_od_cmd: assert property (@(posedge i_card_clk)
      disable iff (lrst_m[1])
      (!ctl_s[2] && !o_cmd_oe_n) |-> !o_cmd_out)
      else $error("command line driven high in open-drain");
endmodule
`default_nettype wire

// ==== hdl/emmc_sig_pkg.sv ====
// Constants shared by the card-bus signalling layer and its link end.
// Assumes a core clock of 40 MHz and an APB master on the core side.
package emmc_sig_pkg;
   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_TXDATA = 12'h008;
   localparam logic [11:0] OFS_CAP    = 12'h00C;
   localparam logic [11:0] OFS_OCR    = 12'h010;
   // CTRL fields.
   localparam int CTRL_WIDTH_LSB = 0;
   localparam int CTRL_CMD_PP    = 2;
   localparam int CTRL_DDR       = 3;
   localparam int CTRL_STROBE    = 4;
   localparam int CTRL_RST_EN    = 5;
   localparam int CTRL_LV18      = 6;
   localparam int CTRL_SOFT_RST  = 7;
   localparam int CTRL_RESP_EN   = 8;
   localparam int CTRL_CRC_STAT  = 9;
   localparam int CTRL_DRIVE     = 10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Bus width codes.
   localparam logic [1:0] WIDTH_1 = 2'h0;
   localparam logic [1:0] WIDTH_4 = 2'h1;
   localparam logic [1:0] WIDTH_8 = 2'h2;
   // Capacity limit for byte addressing, in 512-byte sectors.
   localparam logic [31:0] BYTE_ADDR_LIMIT = 32'h0040_0000;
   localparam logic [1:0]  OCR_MODE_BYTE   = 2'h0;
   localparam logic [1:0]  OCR_MODE_SECTOR = 2'h2;
   localparam int          OCR_MODE_LSB    = 29;
   localparam int          SECTOR_SHIFT    = 9;
endpackage

// ==== hdl/emmc_link_end.sv ====
// Link-side end: runs on the host card clock, shifts command and data.
// Assumes control levels come in already synchronised to the card clock.
`timescale 1ns/1ps
`default_nettype none
module emmc_link_end
   import emmc_sig_pkg::*;
(
   // Link clock and reset.
   input  wire logic       i_card_clk,
   input  wire logic       i_link_rst,
   // Control levels, synchronised.
   input  wire logic [1:0] i_width,
   input  wire logic       i_cmd_pp,
   input  wire logic       i_ddr,
   input  wire logic       i_strobe_mode,
   input  wire logic       i_drive,
   input  wire logic       i_resp_en,
   input  wire logic       i_crc_stat,
   input  wire logic [7:0] i_tx_byte,
   // Card pins.
   input  wire logic       i_cmd_in,
   output logic            o_cmd_out,
   output logic            o_cmd_oe_n,
   output logic [7:0]      o_dat_out,
   output logic [7:0]      o_dat_oe_n,
   output logic            o_strobe,
   // Captured command bits.
   output logic [7:0]      o_cmd_shift
);
   // ****************************************************************
   // Command capture and response drive.
   // ****************************************************************
   logic [7:0] cmd_shift;
   logic       resp_bit;
   logic       cmd_drv;
   logic       strobe_en;
   logic       rise_tgl;
   logic       fall_tgl;
   logic [7:0] data_rise;
   logic [7:0] data_fall;
   logic [7:0] lane_en;

   // One command bit per clock cycle.
   always_ff @(posedge i_card_clk) begin
      if (i_link_rst) begin
         cmd_shift <= 8'h00;
         resp_bit  <= 1'b1;
      end else begin
         cmd_shift <= {cmd_shift[6:0], i_cmd_in};
         resp_bit  <= i_tx_byte[0];
      end
   end
   assign o_cmd_shift = cmd_shift;

   // Responses only, and open-drain drives low only until i_cmd_pp is set.
   assign cmd_drv    = i_resp_en & (i_cmd_pp | ~resp_bit);
   assign o_cmd_out  = i_cmd_pp ? resp_bit : 1'b0;
   assign o_cmd_oe_n = ~cmd_drv;

   // ****************************************************************
   // Data lanes and strobe.
   // ****************************************************************
   // Lane 0 only after reset, and no lane until i_drive is set; wider lanes follow the width field.
   assign lane_en = (i_width == WIDTH_8) ? 8'hFF :
                    (i_width == WIDTH_4) ? 8'h0F : 8'h01;
   assign o_dat_oe_n = ~(lane_en & {8{i_drive}});

   always_ff @(posedge i_card_clk) begin
      if (i_link_rst) begin
         data_rise <= 8'h00;
         rise_tgl  <= 1'b0;
      end else begin
         data_rise <= i_tx_byte;
         rise_tgl  <= ~rise_tgl;
      end
   end

   // Second bit per cycle launched on the falling edge in double rate.
   always_ff @(negedge i_card_clk) begin
      if (i_link_rst) begin
         data_fall <= 8'h00;
         fall_tgl  <= 1'b0;
      end else begin
         data_fall <= i_crc_stat ? data_rise : ~i_tx_byte;
         fall_tgl  <= rise_tgl;
      end
   end

   assign o_dat_out = (i_ddr && !i_card_clk) ? data_fall : data_rise;

   // Strobe follows the clock only in strobe mode with i_drive set, else low.
   assign strobe_en = i_strobe_mode & i_drive;
   assign o_strobe  = strobe_en & (rise_tgl ^ fall_tgl);
endmodule
`default_nettype wire

// ==== testbench/emmc_host_model.sv ====
// Host-side model: card clock and command line for the signalling block.
// Assumes the bench opens frames with i_run or with a pulse on i_send.
`timescale 1ns/1ps
`default_nettype none
module emmc_host_model (
   // Bench control.
   input  wire logic       i_run,
   input  wire logic       i_send,
   input  wire logic [7:0] i_cmd_byte,
   // Device command pin.
   input  wire logic       i_cmd_out,
   input  wire logic       i_cmd_oe_n,
   // Bus lines.
   output logic            o_card_clk,
   output logic            o_cmd_line
);
   // ****************************************************************
   // Clock stands low between frames; any rate is legal.
   // ****************************************************************
   logic host_on = 1'b0;
   logic host_bit = 1'b1;
   logic frame = 1'b0;
   initial begin
      o_card_clk = 1'b0;
      #7;
      forever begin
         if (i_run || frame) begin
            #15 o_card_clk = 1'b1;
            #15 o_card_clk = 1'b0;
         end else begin
            wait (i_run || frame);
         end
      end
   end
   // Sends one command byte, most significant bit first; the clock stops
   // low right after the edge that samples the last bit.
   always @(posedge i_send) begin : send_cmd
      int k;
      frame = 1'b1;
      for (k = 7; k >= 0; k--) begin
         @(negedge o_card_clk);
         host_on  = 1'b1;
         host_bit = i_cmd_byte[k];
      end
      @(posedge o_card_clk);
      frame = 1'b0;
      @(negedge o_card_clk);
      host_on = 1'b0;
   end
   // The line has a pull-up; the host never drives the data lanes.
   assign o_cmd_line = host_on ? host_bit : (!i_cmd_oe_n ? i_cmd_out : 1'b1);
endmodule
`default_nettype wire

// ==== testbench/test_emmc_bus_signalling_device_side.sv ====
// Self-checking bench for the card-bus signalling block.
// Assumes the host model supplies the card clock and command line.
`timescale 1ns/1ps
`default_nettype none
module test_emmc_bus_signalling_device_side import emmc_sig_pkg::*;;
   logic        i_core_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        i_hw_rst_n = 1'b1;
   logic        run = 1'b1;
   logic        send = 1'b0;
   logic [7:0]  cmd_byte = 8'h00;
   logic        pready, pslverr, card_clk, cmd_line, o_cmd_out, o_cmd_oe_n;
   logic        o_strobe, o_byte_mode, rd_e, s;
   logic [31:0] prdata, o_mem_addr, rd_q, w;
   logic [7:0]  o_dat_out, o_dat_oe_n, o_dat_pullup, b;
   logic [1:0]  wtab [3] = '{WIDTH_1, WIDTH_4, WIDTH_8};
   int          mismatches = 0;
   int          cmp_count = 0;
   int          i, cnt;
   localparam logic [31:0] B_DRV = 32'h1 << CTRL_DRIVE;
   localparam logic [31:0] B_HS = (32'h1 << CTRL_DDR) | (32'h1 << CTRL_STROBE);
   always #12.5 i_core_clk = ~i_core_clk;
   emmc_signalling u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .i_card_clk(card_clk), .i_hw_rst_n(i_hw_rst_n), .i_cmd_in(cmd_line),
      .o_cmd_out(o_cmd_out), .o_cmd_oe_n(o_cmd_oe_n), .o_dat_out(o_dat_out),
      .o_dat_oe_n(o_dat_oe_n), .o_dat_pullup(o_dat_pullup),
      .o_strobe(o_strobe), .o_byte_mode(o_byte_mode), .o_mem_addr(o_mem_addr));
   emmc_host_model u_host (.i_run(run), .i_send(send), .i_cmd_byte(cmd_byte),
      .i_cmd_out(o_cmd_out), .i_cmd_oe_n(o_cmd_oe_n), .o_card_clk(card_clk),
      .o_cmd_line(cmd_line));
   // ****************************************************************
   // Tasks and expectations.
   // ****************************************************************
   function automatic logic [7:0] lanes_off(input logic [1:0] wd);
      return (wd == WIDTH_8) ? 8'h00 : (wd == WIDTH_4) ? 8'hF0 : 8'hFE;
   endfunction
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         test_done();
      end
      rd_q = prdata;
      rd_e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task automatic toggles(output int c);
      c = 0;
      repeat (40) begin
         s = o_strobe;
         @(posedge i_core_clk);
         if (o_strobe !== s) c++;
      end
   endtask
   initial begin
      repeat (100000) @(posedge i_core_clk);
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
   end
   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      void'($urandom(44));
      repeat (8) @(posedge i_core_clk);
      i_rst <= 1'b0;
      tick(4);
      check(32'(o_dat_oe_n), 32'h0000_00FF, "oe after reset");
      check(32'(o_dat_pullup), 32'h0000_00FE, "pullup after reset");
      check(32'(o_strobe), 32'h0, "strobe after reset");
      check(32'(o_byte_mode), 32'h0, "byte mode");
      apb(1'b0, OFS_OCR, 32'h0);
      check(32'(rd_q[30:29]), 32'(OCR_MODE_SECTOR), "ocr mode");
      apb(1'b0, OFS_CAP, 32'h0);
      check(rd_q, 32'h0100_0000, "capacity");
      apb(1'b0, 12'h020, 32'h0);
      check({rd_q[30:0], rd_e}, 32'h1, "unmapped read");
      apb(1'b1, 12'h024, 32'hFFFF_FFFF);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd_q, CTRL_RESET, "unmapped write leaked");
      $display("test reset done");
      for (i = 0; i < 3; i++) begin
         apb(1'b1, OFS_CTRL, 32'(wtab[i]) | B_DRV);
         tick(10);
         check(32'(o_dat_pullup), 32'(lanes_off(wtab[i])), "pullup");
         check(32'(o_dat_oe_n), 32'(lanes_off(wtab[i])), "lanes");
      end
      $display("test width done");
      w = 32'(WIDTH_8) | B_DRV | B_HS;
      apb(1'b1, OFS_CTRL, w);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(32'(rd_q[CTRL_STROBE]), 32'h0, "strobe without 1.8V");
      toggles(cnt);
      check(32'(cnt), 32'h0, "strobe idle");
      w = w | (32'h1 << CTRL_LV18);
      apb(1'b1, OFS_CTRL, w);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(32'(rd_q[CTRL_STROBE]), 32'h1, "strobe mode");
      toggles(cnt);
      check(32'(cnt >= 4), 32'h1, "strobe runs");
      run <= 1'b0;
      tick(4);
      toggles(cnt);
      check(32'(cnt), 32'h0, "strobe on stopped clock");
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd_q, w, "state on stopped clock");
      run <= 1'b1;
      $display("test strobe done");
      b = 8'($urandom);
      apb(1'b1, OFS_TXDATA, 32'(b));
      apb(1'b1, OFS_CTRL, 32'(WIDTH_8) | B_DRV |
          (32'h1 << CTRL_RESP_EN) | (32'h1 << CTRL_CMD_PP));
      tick(10);
      check(32'(o_dat_out), 32'(b), "data lanes");
      check(32'(o_dat_oe_n), 32'h0, "all lanes driven");
      check(32'(o_cmd_oe_n), 32'h0, "push-pull response");
      check(32'(o_cmd_out), 32'(b[0]), "response bit");
      $display("test data done");
      apb(1'b1, OFS_CTRL, 32'(WIDTH_4));
      i_hw_rst_n <= 1'b0;
      tick(6);
      i_hw_rst_n <= 1'b1;
      tick(6);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd_q, 32'(WIDTH_4), "pin reset not ignored");
      apb(1'b1, OFS_CTRL, 32'(WIDTH_4) | (32'h1 << CTRL_RST_EN));
      i_hw_rst_n <= 1'b0;
      tick(6);
      i_hw_rst_n <= 1'b1;
      tick(10);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd_q, CTRL_RESET, "pin reset");
      check(32'(o_dat_pullup), 32'h0000_00FE, "pullup after pin reset");
      apb(1'b1, OFS_CTRL, 32'(WIDTH_8) | (32'h1 << CTRL_SOFT_RST));
      tick(10);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd_q, CTRL_RESET, "reset command");
      $display("test reset paths done");
      run <= 1'b0;
      tick(4);
      for (i = 0; i < 5; i++) begin
         b = (i == 0) ? 8'hA5 : 8'($urandom);
         cmd_byte <= b;
         send     <= 1'b1;
         tick(2);
         send     <= 1'b0;
         tick(30);
         check(32'(o_cmd_oe_n), 32'h1, "device drove command");
         apb(1'b0, OFS_STATUS, 32'h0);
         check(32'(rd_q[7:0]), 32'(b), "command bits");
         check(o_mem_addr, 32'(b) << SECTOR_SHIFT, "sector addr");
      end
      $display("test command done");
      test_done();
   end
endmodule
`default_nettype wire
